// ==== hw/aefd_pkg.sv ====
// package: register map, feature codes and shared types for the extended-feature dispatch
package aefd_pkg;
    // ==========================================================
    // geometry
    localparam int NUM_CH = 14;
    localparam int CH_W = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int NUM_CFG = 7;
    localparam int NUM_RES = 4;
    localparam int ALL_CH_COUNT = 128;

    // ==========================================================
    // register map (printed start addresses, one word step per channel, FLOAT32/UINT32 = 2)
    localparam logic [ADDR_W-1:0] ADDR_RESULT_PRIMARY = 16'h1b58;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_SECOND = 16'h1c84;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_THIRD = 16'h1db0;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_FOURTH = 16'h1edc;
    localparam logic [ADDR_W-1:0] ADDR_SELECT_INDEX = 16'h2328;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_FIRST = 16'h2454;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_SECOND = 16'h2580;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_THIRD = 16'h26ac;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_FOURTH = 16'h27d8;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_FIFTH = 16'h2904;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_SIXTH = 16'h2a30;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_SEVENTH = 16'h2b5c;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_SELECT = 16'hab82;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0002;

    // ==========================================================
    // values
    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [DATA_W-1:0] MIXED_INDEX_WORD = 32'h0000_ffff;
    localparam logic [DATA_W-1:0] UNMAPPED_WORD = 32'h0000_0000;

    // ==========================================================
    // feature codes
    localparam logic [7:0] FEAT_NONE = 8'h00;
    localparam logic [7:0] FEAT_OFFSET_SLOPE = 8'h01;
    localparam logic [7:0] FEAT_MAX_MIN_AVG = 8'h03;
    localparam logic [7:0] FEAT_RESISTANCE = 8'h04;
    localparam logic [7:0] FEAT_AVG_THRESH = 8'h05;
    localparam logic [7:0] FEAT_RMS_FLEX = 8'h0a;
    localparam logic [7:0] FEAT_RMS_AUTO = 8'h0b;
    localparam logic [7:0] FEAT_TC_FIRST = 8'h14;
    localparam logic [7:0] FEAT_TC_LAST = 8'h19;
    localparam logic [7:0] FEAT_TC_C = 8'h1e;
    localparam logic [7:0] FEAT_RTD_FIRST = 8'h28;
    localparam logic [7:0] FEAT_RTD_LAST = 8'h2a;
    localparam logic [7:0] FEAT_THERM_SH = 8'h32;
    localparam logic [7:0] FEAT_THERM_BETA = 8'h33;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        CLS_NONE = 4'h0,
        CLS_OFFSET_SLOPE = 4'h1,
        CLS_STATS = 4'h2,
        CLS_RESISTANCE = 4'h3,
        CLS_THRESH = 4'h4,
        CLS_RMS = 4'h5,
        CLS_THERMOCOUPLE = 4'h6,
        CLS_RTD = 4'h7,
        CLS_THERMISTOR = 4'h8,
        CLS_INVALID = 4'hf
    } aefd_class_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_DONE = 2'b11
    } aefd_state_t;

    // host register access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } aefd_req_t;

    // request towards the feature math engine
    typedef struct packed {
        logic start;
        logic [CH_W-1:0] ch;
        aefd_class_t cls;
        logic burst;
        logic [7:0] index;
    } aefd_job_t;

    // answer from the feature math engine
    typedef struct packed {
        logic done;
        logic [DATA_W-1:0] res_a;
        logic [DATA_W-1:0] res_b;
        logic [DATA_W-1:0] res_c;
        logic [DATA_W-1:0] res_d;
    } aefd_ans_t;
endpackage

// ==== hw/aefd_dispatch.sv ====
// module: per-channel extended-feature register file and primary-read dispatch
// Function
// - one feature per channel, from its index
// - decode 0,1,3,4,5,10,11 base features
// - decode thermocouple, RTD and thermistor codes
// - features 3,5,10,11 acquire via burst
// - command-response only, never in stream mode
// - global write of zero disables all
// - global read: common index or 0xFFFF; only an all-zero set counts as common here
// - config words meaning follows channel index
// - ordinary analog settings used for acquisition
// - only primary read starts math, returns result
// - secondary results latched at primary completion
// - burst read completes after all samples
// - secondary reads never start acquisition
`timescale 1ns/100ps
module aefd_dispatch
    import aefd_pkg::*;
#(
    parameter bit HIGH_VARIANT = 1'b1
) (
    // clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // host register access
    input wire aefd_pkg::aefd_req_t I_REQ,
    output logic O_ACK,
    output logic O_ERR,
    output logic [aefd_pkg::DATA_W-1:0] O_RDATA,
    // analog system mode
    input wire logic I_STREAM_ACTIVE,
    // feature engine
    output aefd_pkg::aefd_job_t O_JOB,
    output logic [aefd_pkg::NUM_CFG*aefd_pkg::DATA_W-1:0] O_JOB_CFG,
    input wire aefd_pkg::aefd_ans_t I_ANS
);
    import aefd_pkg::*;

    // ==========================================================
    // decode helpers
    // bus in short: one access at a time, rd/wr held until O_ACK and
    // dropped the cycle after; each access gets exactly one ack pulse,
    // a primary read outside stream mode only once the engine reports done
    // whole 32-bit index compared, so junk in the upper bits never
    // passes for a valid low code; the engine owns the error for
    // CLS_INVALID, the dispatch still starts the job
    function automatic aefd_class_t classify(input logic [DATA_W-1:0] idx);
        aefd_class_t c;
        c = CLS_INVALID;
        if (idx[DATA_W-1:8] == '0) begin
            case (idx[7:0])
                FEAT_NONE: c = CLS_NONE;
                FEAT_OFFSET_SLOPE: c = CLS_OFFSET_SLOPE;
                FEAT_MAX_MIN_AVG: c = CLS_STATS;
                FEAT_RESISTANCE: c = CLS_RESISTANCE;
                FEAT_AVG_THRESH: c = CLS_THRESH;
                FEAT_RMS_FLEX, FEAT_RMS_AUTO: c = CLS_RMS;
                FEAT_THERM_SH, FEAT_THERM_BETA: c = CLS_THERMISTOR;
                default: begin
                    // thermocouples only exist on the larger variant
                    // without it those codes fall through to invalid
                    if (HIGH_VARIANT && ((idx[7:0] >= FEAT_TC_FIRST && idx[7:0] <= FEAT_TC_LAST)
                        || idx[7:0] == FEAT_TC_C)) begin
                        c = CLS_THERMOCOUPLE;
                    end else if (idx[7:0] >= FEAT_RTD_FIRST && idx[7:0] <= FEAT_RTD_LAST) begin
                        c = CLS_RTD;
                    end else begin
                        c = CLS_INVALID;
                    end
                end
            endcase
        end
        return c;
    endfunction

    // burst features run an internal stream; the engine takes
    // this flag to pick its long acquisition path
    function automatic logic is_burst(input logic [7:0] idx);
        return idx == FEAT_MAX_MIN_AVG || idx == FEAT_AVG_THRESH
            || idx == FEAT_RMS_FLEX || idx == FEAT_RMS_AUTO;
    endfunction

    // channel hit within a per-channel bank: returns valid flag and channel
    // 32-bit words, two address units per channel; odd offsets
    // and anything past the last channel miss every bank
    function automatic logic [CH_W:0] bank_hit(input logic [ADDR_W-1:0] a,
                                               input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        logic [CH_W:0] r;
        off = a - base;
        r = '0;
        if (a >= base && off[0] == 1'b0 && off[ADDR_W-1:1] < ADDR_W'(NUM_CH)) begin
            r = {1'b1, off[CH_W:1]};
        end
        return r;
    endfunction

    // ==========================================================
    // storage
    // small enough for flops; index words kept whole so a read
    // gives back exactly what the host wrote
    logic [DATA_W-1:0] index_ff [NUM_CH];
    logic [DATA_W-1:0] cfg_ff [NUM_CH][NUM_CFG];
    logic [DATA_W-1:0] res_ff [NUM_CH][NUM_RES];
    aefd_state_t state_ff;
    logic [CH_W-1:0] job_ch_ff;
    aefd_job_t job_ff;
    logic ack_ff;
    logic err_ff;
    logic [DATA_W-1:0] rdata_ff;

    // ==========================================================
    // address decode
    // bases lie far apart, so at most one bank hits an address
    logic [ADDR_W-1:0] cfg_base [NUM_CFG];
    logic [CH_W:0] hit_cfg [NUM_CFG];
    logic [CH_W:0] hit_res [NUM_RES];
    logic [CH_W:0] hit_idx;
    logic hit_global;
    logic [ADDR_W-1:0] res_base [NUM_RES];

    assign cfg_base[0] = ADDR_CONFIG_FIRST;
    assign cfg_base[1] = ADDR_CONFIG_SECOND;
    assign cfg_base[2] = ADDR_CONFIG_THIRD;
    assign cfg_base[3] = ADDR_CONFIG_FOURTH;
    assign cfg_base[4] = ADDR_CONFIG_FIFTH;
    assign cfg_base[5] = ADDR_CONFIG_SIXTH;
    assign cfg_base[6] = ADDR_CONFIG_SEVENTH;
    assign res_base[0] = ADDR_RESULT_PRIMARY;
    assign res_base[1] = ADDR_RESULT_SECOND;
    assign res_base[2] = ADDR_RESULT_THIRD;
    assign res_base[3] = ADDR_RESULT_FOURTH;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg_hit
            assign hit_cfg[gi] = bank_hit(I_REQ.addr, cfg_base[gi]);
        end
        for (gi = 0; gi < NUM_RES; gi++) begin : g_res_hit
            assign hit_res[gi] = bank_hit(I_REQ.addr, res_base[gi]);
        end
    endgenerate
    assign hit_idx = bank_hit(I_REQ.addr, ADDR_SELECT_INDEX);
    assign hit_global = I_REQ.addr == ADDR_GLOBAL_SELECT;

    // new access taken only while idle; a blocked primary read holds the bus
    // the ack cycle counts as busy too: the host still shows the
    // old request then, and it must not be taken twice
    logic idle;
    logic take_rd;
    logic take_wr;
    logic start_primary;
    assign idle = state_ff == ST_IDLE && !ack_ff;
    assign take_rd = I_CE && idle && I_REQ.rd;
    assign take_wr = I_CE && idle && I_REQ.wr && !I_REQ.rd;
    // stream mode owns the converter, so no feature read can run then
    assign start_primary = take_rd && hit_res[0][CH_W] && !I_STREAM_ACTIVE;

    // ==========================================================
    // global index agreement; channels beyond this block read as disabled
    // limitation: only an all-disabled set can agree, so any
    // enabled channel makes the global read show mixed
    logic all_same;
    always_comb begin
        all_same = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (index_ff[i] != ((NUM_CH < ALL_CH_COUNT) ? RESET_WORD : index_ff[0])) begin
                all_same = 1'b0;
            end
        end
    end

    // ==========================================================
    // index registers: per-channel writes and global disable
    // a non-zero global write changes nothing; the answer path
    // refuses it rather than loading one value everywhere
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                index_ff[i] <= RESET_WORD;
            end
        end else if (take_wr) begin
            if (hit_global && I_REQ.wdata == RESET_WORD) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    index_ff[i] <= RESET_WORD;
                end
            end else if (hit_idx[CH_W] && hit_idx[CH_W-1:0] < CH_W'(NUM_CH)) begin
                index_ff[hit_idx[CH_W-1:0]] <= I_REQ.wdata;
            end
        end
    end

    // ==========================================================
    // config words stored raw; meaning is left to the engine per index
    // no checks: which words matter depends on the feature
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                for (int k = 0; k < NUM_CFG; k++) begin
                    cfg_ff[i][k] <= RESET_WORD;
                end
            end
        end else if (take_wr) begin
            for (int k = 0; k < NUM_CFG; k++) begin
                if (hit_cfg[k][CH_W]) begin
                    cfg_ff[hit_cfg[k][CH_W-1:0]][k] <= I_REQ.wdata;
                end
            end
        end
    end

    // ==========================================================
    // acquisition sequencer
    // idle -> acq on a primary read, acq -> done on the engine's
    // done pulse, done -> idle while the ack goes out
    // hazard: the engine must share I_CE; a done pulse seen with
    // the enable low is lost and the read is never answered
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            state_ff <= ST_IDLE;
            job_ch_ff <= '0;
            job_ff <= '0;
        end else if (I_CE) begin
            job_ff.start <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (start_primary) begin
                        state_ff <= ST_ACQ;
                        job_ch_ff <= hit_res[0][CH_W-1:0];
                        job_ff.start <= 1'b1;
                        job_ff.ch <= hit_res[0][CH_W-1:0];
                        job_ff.index <= index_ff[hit_res[0][CH_W-1:0]][7:0];
                        job_ff.cls <= classify(index_ff[hit_res[0][CH_W-1:0]]);
                        job_ff.burst <= is_burst(index_ff[hit_res[0][CH_W-1:0]][7:0]);
                    end
                end
                ST_ACQ: begin
                    // burst features hold here until the engine has every sample
                    // plain features answer after one engine cycle
                    if (I_ANS.done) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // result registers: secondary words latched when the primary completes
    // completion beats a host write, though the bus is busy then
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < NUM_CH; i++) begin
                for (int k = 0; k < NUM_RES; k++) begin
                    res_ff[i][k] <= RESET_WORD;
                end
            end
        end else if (I_CE) begin
            if (state_ff == ST_ACQ && I_ANS.done) begin
                res_ff[job_ch_ff][0] <= I_ANS.res_a;
                res_ff[job_ch_ff][1] <= I_ANS.res_b;
                res_ff[job_ch_ff][2] <= I_ANS.res_c;
                res_ff[job_ch_ff][3] <= I_ANS.res_d;
            end else if (take_wr) begin
                // second and third results are host-writable; fourth is read-only
                // primary and fourth writes are refused on the answer path
                for (int k = 1; k < NUM_RES - 1; k++) begin
                    if (hit_res[k][CH_W]) begin
                        res_ff[hit_res[k][CH_W-1:0]][k] <= I_REQ.wdata;
                    end
                end
            end
        end
    end

    // ==========================================================
    // host answer: one cycle after an access, or on engine completion
    // data and error from flops, settled for a full cycle; read
    // data stays put until the next read answer replaces it
    // a primary read refused in stream mode answers zero
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= RESET_WORD;
        end else if (I_CE) begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
            if (state_ff == ST_ACQ && I_ANS.done) begin
                ack_ff <= 1'b1;
                rdata_ff <= I_ANS.res_a;
            end else if (take_rd && !start_primary) begin
                ack_ff <= 1'b1;
                rdata_ff <= UNMAPPED_WORD;
                if (hit_res[0][CH_W]) begin
                    err_ff <= 1'b1;
                end else if (hit_global) begin
                    rdata_ff <= all_same ? index_ff[0] : MIXED_INDEX_WORD;
                end else if (hit_idx[CH_W]) begin
                    rdata_ff <= index_ff[hit_idx[CH_W-1:0]];
                end else begin
                    for (int k = 0; k < NUM_CFG; k++) begin
                        if (hit_cfg[k][CH_W]) begin
                            rdata_ff <= cfg_ff[hit_cfg[k][CH_W-1:0]][k];
                        end
                    end
                    for (int k = 1; k < NUM_RES; k++) begin
                        if (hit_res[k][CH_W]) begin
                            rdata_ff <= res_ff[hit_res[k][CH_W-1:0]][k];
                        end
                    end
                end
            end else if (take_wr) begin
                ack_ff <= 1'b1;
                // only zero may go to the global select
                // the two read-only results refuse writes as well
                err_ff <= (hit_global && I_REQ.wdata != RESET_WORD)
                    || hit_res[0][CH_W] || hit_res[3][CH_W];
            end
        end
    end

    // ==========================================================
    // outputs; engine uses channel's ordinary analog settings itself
    // no feature copies of range or settling exist here; the
    // config words follow the running job's channel
    assign O_ACK = ack_ff;
    assign O_ERR = err_ff;
    assign O_RDATA = rdata_ff;
    assign O_JOB = job_ff;
    generate
        for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg_out
            assign O_JOB_CFG[gi*DATA_W +: DATA_W] = cfg_ff[job_ch_ff][gi];
        end
    endgenerate
endmodule

// ==== verification/aefd_engine_model.sv ====
// partner: behavioural feature math engine answering dispatch jobs
`timescale 1ns/100ps
module aefd_engine_model
    import aefd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // job in, answer out
    input wire aefd_pkg::aefd_job_t i_job,
    input wire logic [aefd_pkg::NUM_CFG*aefd_pkg::DATA_W-1:0] i_cfg,
    output aefd_pkg::aefd_ans_t o_ans
);
    // ====
    logic [7:0] cnt_ff;
    logic [3:0] ch_ff;
    logic [7:0] idx_ff;
    logic [31:0] cfg_ff;
    logic [127:0] res;
    // burst jobs hold the answer for a long acquisition
    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            cnt_ff <= 8'h00;
        else if (i_job.start)
            cnt_ff <= i_job.burst ? 8'h0c : 8'h01;
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    end
    // job identity captured at start, first config word echoed as result d
    always_ff @(posedge i_clk) begin
        if (i_job.start) begin
            ch_ff <= i_job.ch;
            idx_ff <= i_job.index;
            cfg_ff <= i_cfg[31:0];
        end
    end
    // junk between answers so stale data cannot pass for fresh
    assign res = {8'h0a, 12'h000, ch_ff, idx_ff, 8'h0b, 12'h000, ch_ff, idx_ff,
                  8'h0c, 12'h000, ch_ff, idx_ff, cfg_ff};
    assign o_ans = {cnt_ff == 8'h01, (cnt_ff == 8'h01) ? res : ~res};
endmodule

// ==== verification/aefd_dispatch_chk.sv ====
// checker: port-level properties of the extended-feature dispatch
`timescale 1ns/100ps
module aefd_dispatch_chk
    import aefd_pkg::*;
#(
    parameter bit HIGH_VARIANT = 1'b1
) (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire aefd_pkg::aefd_req_t I_REQ,
    input wire logic O_ACK,
    input wire logic O_ERR,
    input wire logic [aefd_pkg::DATA_W-1:0] O_RDATA,
    input wire logic I_STREAM_ACTIVE,
    input wire aefd_pkg::aefd_job_t O_JOB,
    input wire logic [aefd_pkg::NUM_CFG*aefd_pkg::DATA_W-1:0] O_JOB_CFG,
    input wire aefd_pkg::aefd_ans_t I_ANS
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    // ====
    logic prim_hit;
    // even offsets of the fourteen primary result words
    assign prim_hit = I_REQ.rd && I_REQ.addr >= ADDR_RESULT_PRIMARY
        && I_REQ.addr < ADDR_RESULT_PRIMARY + 16'h001c && !I_REQ.addr[0];
    // expected class, thermocouples only on the higher variant
    function automatic aefd_class_t exp_cls(input logic [7:0] x);
        case (x) inside
            8'h00: return CLS_NONE;
            8'h01: return CLS_OFFSET_SLOPE;
            8'h03: return CLS_STATS;
            8'h04: return CLS_RESISTANCE;
            8'h05: return CLS_THRESH;
            8'h0a, 8'h0b: return CLS_RMS;
            [8'h14:8'h19], 8'h1e: return HIGH_VARIANT ? CLS_THERMOCOUPLE : CLS_INVALID;
            [8'h28:8'h2a]: return CLS_RTD;
            8'h32, 8'h33: return CLS_THERMISTOR;
            default: return CLS_INVALID;
        endcase
    endfunction
    sequence s_start;
        O_JOB.start && I_CE;
    endsequence
    sequence s_answer;
        I_ANS.done && I_CE;
    endsequence
    AST_ACK_PULSE: assert property (O_ACK |=> !O_ACK) else $error("ack longer than one cycle");
    AST_ERR_WITH_ACK: assert property (O_ERR |-> O_ACK) else $error("error without ack");
    AST_START_CAUSE: assert property (s_start |-> $past(prim_hit))
        else $error("job started without primary read");
    AST_NO_STREAM_JOB: assert property (s_start |-> !$past(I_STREAM_ACTIVE))
        else $error("job started in stream mode");
    AST_CLASS: assert property (s_start |-> O_JOB.cls == exp_cls(O_JOB.index))
        else $error("wrong feature class");
    AST_BURST_FLAG: assert property (s_start |-> O_JOB.burst == (O_JOB.index inside
        {8'h03, 8'h05, 8'h0a, 8'h0b})) else $error("wrong burst flag");
    AST_JOB_CH: assert property (s_start |->
        O_JOB.ch == 4'(($past(I_REQ.addr) - ADDR_RESULT_PRIMARY) >> 1))
        else $error("wrong job channel");
    AST_RESULT_A: assert property (s_answer |=> O_ACK && !O_ERR
        && O_RDATA == $past(I_ANS.res_a)) else $error("primary result not returned");
    AST_HOLD_UNTIL_DONE: assert property (s_start |=> !O_ACK until I_ANS.done)
        else $error("primary read answered before engine done");
    AST_ACK_BOUND: assert property (s_start |-> ##[2:40] O_ACK)
        else $error("primary read never answered");
endmodule
bind aefd_dispatch aefd_dispatch_chk #(.HIGH_VARIANT(HIGH_VARIANT)) u_chk (
    .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_REQ(I_REQ), .O_ACK(O_ACK),
    .O_ERR(O_ERR), .O_RDATA(O_RDATA), .I_STREAM_ACTIVE(I_STREAM_ACTIVE), .O_JOB(O_JOB),
    .O_JOB_CFG(O_JOB_CFG), .I_ANS(I_ANS));

// ==== verification/tb_top.sv ====
// testbench: register-level tests of the extended-feature dispatch
`timescale 1ns/100ps
module tb_top;
    import aefd_pkg::*;
    // ====
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic stream = 1'b0;
    aefd_req_t req = '0;
    logic ack;
    logic err;
    logic [31:0] rdata;
    aefd_job_t job;
    logic [223:0] job_cfg;
    aefd_ans_t ans;
    int error_cnt = 0;
    int num_checks = 0;
    int starts = 0;
    logic [31:0] q;
    logic e;
    logic [7:0] codes [18] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0a, 8'h0b, 8'h14, 8'h15,
        8'h16, 8'h17, 8'h18, 8'h19, 8'h1e, 8'h28, 8'h29, 8'h2a, 8'h32, 8'h33};
    logic [15:0] cfgs [7] = '{ADDR_CONFIG_FIRST, ADDR_CONFIG_SECOND, ADDR_CONFIG_THIRD,
        ADDR_CONFIG_FOURTH, ADDR_CONFIG_FIFTH, ADDR_CONFIG_SIXTH, ADDR_CONFIG_SEVENTH};
    aefd_dispatch aefd_dispatch_inst (.I_MCLK(mclk), .I_RST_N(rst_n), .I_CE(ce),
        .I_REQ(req), .O_ACK(ack), .O_ERR(err), .O_RDATA(rdata), .I_STREAM_ACTIVE(stream),
        .O_JOB(job), .O_JOB_CFG(job_cfg), .I_ANS(ans));
    aefd_engine_model aefd_engine_model_inst (.i_clk(mclk), .i_rst_n(rst_n), .i_job(job),
        .i_cfg(job_cfg), .o_ans(ans));
    // clock and job counter
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (job.start === 1'b1) starts <= starts + 1;
    // ====
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access: hold until ack, drop at the ack edge, one idle cycle after
    task automatic acc(input logic r, input logic [15:0] a, input logic [31:0] d,
                       input logic exp_e);
        int n;
        n = 0;
        req <= {r, ~r, a, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 200);
        q = rdata;
        e = err;
        req <= '0;
        @(posedge mclk);
        chk("ack wait", 32'(n >= 200), 32'h0000_0000);
        chk("error flag", {31'h0, e}, {31'h0, exp_e});
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
        acc(1'b1, a, 32'h0000_0000, 1'b0);
        chk(nm, q, exp);
    endtask
    function automatic logic [31:0] res(input logic [7:0] tag, input logic [7:0] idx);
        return {tag, 12'h000, 4'h2, idx};
    endfunction
    task stop_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        stop_test;
    end
    // main sequence, channel 2 unless stated
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdchk("index reset", ADDR_SELECT_INDEX + 16'h001a, 32'h0000_0000);
        for (int k = 0; k < 7; k++) begin
            acc(1'b0, cfgs[k] + 16'h0004, 32'h00c0_0000 + 32'(k), 1'b0);
            rdchk("config", cfgs[k] + 16'h0004, 32'h00c0_0000 + 32'(k));
        end
        rdchk("unmapped", ADDR_SELECT_INDEX + 16'h0001, 32'h0000_0000);
        rdchk("global zero", ADDR_GLOBAL_SELECT, 32'h0000_0000);
        for (int i = 0; i < 18; i++) begin
            acc(1'b0, ADDR_SELECT_INDEX + 16'h0004, {24'h0, codes[i]}, 1'b0);
            rdchk("index", ADDR_SELECT_INDEX + 16'h0004, {24'h0, codes[i]});
            rdchk("result a", ADDR_RESULT_PRIMARY + 16'h0004, res(8'h0a, codes[i]));
            rdchk("result b", ADDR_RESULT_SECOND + 16'h0004, res(8'h0b, codes[i]));
            rdchk("result c", ADDR_RESULT_THIRD + 16'h0004, res(8'h0c, codes[i]));
            rdchk("result d", ADDR_RESULT_FOURTH + 16'h0004, 32'h00c0_0000);
            chk("job count", 32'(starts), 32'(i + 1));
        end
        rdchk("global mixed", ADDR_GLOBAL_SELECT, MIXED_INDEX_WORD);
        stream <= 1'b1;
        acc(1'b1, ADDR_RESULT_PRIMARY + 16'h0004, 32'h0000_0000, 1'b1);
        chk("stream data", q, 32'h0000_0000);
        stream <= 1'b0;
        chk("job count", 32'(starts), 32'h0000_0012);
        acc(1'b0, ADDR_RESULT_PRIMARY + 16'h0004, 32'h0000_0001, 1'b1);
        acc(1'b0, ADDR_RESULT_FOURTH + 16'h0004, 32'h0000_0001, 1'b1);
        acc(1'b0, ADDR_RESULT_SECOND + 16'h0004, 32'h0000_5a5a, 1'b0);
        rdchk("result b write", ADDR_RESULT_SECOND + 16'h0004, 32'h0000_5a5a);
        acc(1'b0, ADDR_GLOBAL_SELECT, 32'h0000_0005, 1'b1);
        rdchk("index kept", ADDR_SELECT_INDEX + 16'h0004, 32'h0000_0033);
        acc(1'b0, ADDR_GLOBAL_SELECT, 32'h0000_0000, 1'b0);
        rdchk("index cleared", ADDR_SELECT_INDEX + 16'h0004, 32'h0000_0000);
        rdchk("global cleared", ADDR_GLOBAL_SELECT, 32'h0000_0000);
        // enable low: the request must stand unanswered until it rises
        ce <= 1'b0;
        fork
            acc(1'b0, ADDR_SELECT_INDEX + 16'h0004, 32'h0000_0001, 1'b0);
            begin
                repeat (4) @(posedge mclk);
                chk("frozen ack", {31'h0, ack}, 32'h0000_0000);
                ce <= 1'b1;
            end
        join
        rdchk("index after enable", ADDR_SELECT_INDEX + 16'h0004, 32'h0000_0001);
        stop_test;
    end
endmodule
